// ==== design/fcp_pkg.sv ====
package fcp_pkg;

	// ----------------------------------------------------------------
	// Register indexes, byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [3:0] FCP_IDX_DIV  = 4'h0;
	localparam logic [3:0] FCP_IDX_SEC  = 4'h1;
	localparam logic [3:0] FCP_IDX_TST  = 4'h2;
	localparam logic [3:0] FCP_IDX_CFG  = 4'h3;
	localparam logic [3:0] FCP_IDX_PROT = 4'h4;
	localparam logic [3:0] FCP_IDX_STAT = 4'h5;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int FCP_DIV_LOADED = 7;
	localparam int FCP_DIV_PRE    = 6;
	localparam int FCP_TST_BROADCAST_WRITE  = 4;
	localparam int FCP_CFG_BEIE   = 7;
	localparam int FCP_CFG_COMPLETE_IRQ_ENABLE   = 6;
	localparam int FCP_CFG_KEY    = 5;
	localparam int FCP_CFG_BANK   = 0;
	localparam int FCP_SEC_BACKDOOR_ALLOW  = 7;
	localparam int FCP_PR_OPEN    = 7;
	localparam int FCP_PR_NV6     = 6;
	localparam int FCP_PR_HDIS    = 5;
	localparam int FCP_PR_HS_LO   = 3;
	localparam int FCP_PR_LDIS    = 2;
	localparam int FCP_PR_LS_LO   = 0;
	localparam int FCP_ST_BEF     = 7;
	localparam int FCP_ST_CCF     = 6;
	localparam int FCP_ST_GUARD_VIOLATION_FLAG   = 5;

	// ----------------------------------------------------------------
	// Values and addresses
	// ----------------------------------------------------------------
	localparam logic [1:0]  FCP_UNSECURED = 2'h2;
	localparam logic [1:0]  FCP_RESP_OK   = 2'h0;
	localparam logic [1:0]  FCP_RESP_ERR  = 2'h2;
	localparam logic [15:0] FCP_NV_SEC    = 16'hff0f;
	localparam logic [15:0] FCP_NV_PROT0  = 16'hff0d;
	localparam logic [15:0] FCP_NV_PROT1  = 16'hff0c;
	localparam logic [15:0] FCP_HI_MIN    = 16'h0800;
	localparam logic [15:0] FCP_LO_MIN    = 16'h0200;
	localparam logic [15:0] FCP_LO_BASE   = 16'h8000;
	localparam logic [15:0] FCP_TOP       = 16'hffff;
	localparam logic [2:0]  FCP_PRE_LAST  = 3'h7;

	typedef enum logic [1:0] {
		FCP_LD_SEC,
		FCP_LD_PROT0,
		FCP_LD_PROT1,
		FCP_LD_DONE
	} fcp_ld_t;

	// Protection write: clear-only bits, sizes held once guard is on.
	function automatic logic [7:0] fcp_prot_write(input logic [7:0] o,
		input logic [7:0] n);
		logic [7:0] r;
		begin
			r = o & 8'h40;
			r[FCP_PR_OPEN] = o[FCP_PR_OPEN] & n[FCP_PR_OPEN];
			r[FCP_PR_HDIS] = o[FCP_PR_HDIS] & n[FCP_PR_HDIS];
			r[FCP_PR_LDIS] = o[FCP_PR_LDIS] & n[FCP_PR_LDIS];
			r[4:3] = o[FCP_PR_HDIS] ? n[4:3] : o[4:3];
			r[1:0] = o[FCP_PR_LDIS] ? n[1:0] : o[1:0];
			return r;
		end
	endfunction

	// True when the target of a program or erase lies under protection.
	function automatic logic fcp_is_protected(input logic [7:0] p,
		input logic [15:0] a, input logic mass);
		logic [15:0] hsz;
		logic [15:0] lsz;
		logic        hi;
		logic        lo;
		begin
			hsz = FCP_HI_MIN << p[4:3];
			lsz = FCP_LO_MIN << p[1:0];
			hi = !p[FCP_PR_HDIS] && (a > (FCP_TOP - hsz));
			lo = !p[FCP_PR_LDIS] && (a >= FCP_LO_BASE) &&
				(a < (FCP_LO_BASE + lsz));
			if (!p[FCP_PR_OPEN])
				return 1'b1;
			if (mass)
				return !(p[FCP_PR_HDIS] && p[FCP_PR_LDIS]);
			return hi || lo;
		end
	endfunction

endpackage

// ==== design/fcp_clkdiv.sv ====
`timescale 1ns/1ps
module fcp_clkdiv
	import fcp_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	// Control
	input  wire logic       osc_tick_in,
	input  wire logic       enable_in,
	input  wire logic       prescale_in,
	input  wire logic [5:0] div_in,
	// Timebase
	output logic            tick_out
);
	logic [2:0] pre_cnt;
	logic [5:0] div_cnt;
	logic       pre_done;

	// The prescaler passes every eighth oscillator tick when selected.
	assign pre_done = osc_tick_in && (!prescale_in || pre_cnt == FCP_PRE_LAST);

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			pre_cnt  <= 3'h0;
			div_cnt  <= 6'h0;
			tick_out <= 1'b0;
		end else begin
			tick_out <= 1'b0;
			if (enable_in && osc_tick_in)
				pre_cnt <= pre_cnt + 3'h1;
			if (enable_in && pre_done) begin
				if (div_cnt == div_in) begin
					div_cnt  <= 6'h0;
					tick_out <= 1'b1;
				end else begin
					div_cnt <= div_cnt + 6'h1;
				end
			end
		end
	end
endmodule

// ==== design/fcp_nvload.sv ====
`timescale 1ns/1ps
module fcp_nvload
	import fcp_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	// Nonvolatile read port
	output logic             rd_req_out,
	output logic [15:0]      rd_addr_out,
	input  wire logic [7:0]  rd_data_in,
	input  wire logic        rd_valid_in,
	// Loaded bytes
	output logic             load_strobe_out,
	output fcp_ld_t          load_sel_out,
	output logic [7:0]       load_data_out,
	output logic             done_out
);
	fcp_ld_t state;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			state           <= FCP_LD_SEC;
			rd_req_out      <= 1'b1;
			rd_addr_out     <= FCP_NV_SEC;
			load_strobe_out <= 1'b0;
			load_sel_out    <= FCP_LD_SEC;
			load_data_out   <= 8'h00;
			done_out        <= 1'b0;
		end else begin
			load_strobe_out <= 1'b0;
			if (rd_req_out && rd_valid_in) begin
				load_strobe_out <= 1'b1;
				load_sel_out    <= state;
				load_data_out   <= rd_data_in;
				unique case (state)
					FCP_LD_SEC: begin
						state       <= FCP_LD_PROT0;
						rd_addr_out <= FCP_NV_PROT0;
					end
					FCP_LD_PROT0: begin
						state       <= FCP_LD_PROT1;
						rd_addr_out <= FCP_NV_PROT1;
					end
					FCP_LD_PROT1: begin
						state      <= FCP_LD_DONE;
						rd_req_out <= 1'b0;
					end
					FCP_LD_DONE: begin
						rd_req_out <= 1'b0;
					end
				endcase
			end
			if (state == FCP_LD_DONE)
				done_out <= 1'b1;
		end
	end
endmodule

// ==== design/fcp_top.sv ====
`timescale 1ns/1ps
module fcp_top
	import fcp_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        reset_in,
	// AXI4-Lite write address and data
	input  wire logic [7:0]  s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp_out,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	// Oscillator and timebase
	input  wire logic        osc_tick_in,
	output logic             fclk_tick_out,
	// Mode and security events
	input  wire logic        special_mode_in,
	input  wire logic        backdoor_unlock_in,
	// Command machine flags per bank
	input  wire logic [1:0]  buffer_empty_flag_in,
	input  wire logic [1:0]  complete_flag_in,
	// Nonvolatile read port
	output logic             nv_rd_req_out,
	output logic [15:0]      nv_rd_addr_out,
	input  wire logic [7:0]  nv_rd_data_in,
	input  wire logic        nv_rd_valid_in,
	// Program and erase check
	input  wire logic        op_req_in,
	input  wire logic        op_bank_in,
	input  wire logic [15:0] op_addr_in,
	input  wire logic        op_mass_in,
	output logic             op_grant_out,
	output logic             op_refuse_out,
	output logic             launch_block_out,
	// Control outputs
	output logic             irq_buffer_empty_out,
	output logic             irq_complete_out,
	output logic             key_write_gate_out,
	output logic             array_read_invalid_out,
	output logic             bank_choose_out,
	output logic             broadcast_write_out,
	output logic             secured_out,
	output logic             backdoor_allow_out
);
	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic       div_loaded;
	logic       prescale_select;
	logic [5:0] divide_field;
	logic [7:0] lock_register;
	logic       broadcast_write;
	logic       buffer_empty_irq_enable;
	logic       complete_irq_enable;
	logic       key_write_gate;
	logic       bank_choose;
	logic [7:0] protect_register [2];
	logic [1:0] guard_violation_flag;

	logic        aw_got;
	logic        w_got;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        next_aw_got;
	logic        next_w_got;
	logic        next_bvalid;
	logic        next_rvalid;
	logic        do_write;
	logic        aw_take;
	logic        w_take;
	logic        ar_take;
	logic [3:0]  aw_idx;
	logic [3:0]  ar_idx;
	logic        aw_map;
	logic        ar_map;
	logic        wr_lane;
	logic        broadcast_write_eff;
	logic [1:0]  bank_hit;
	logic [7:0]  rd_byte;
	logic        viol;

	logic        ld_strobe;
	fcp_ld_t     ld_sel;
	logic [7:0]  ld_data;
	logic        ld_done;

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	fcp_nvload u_nvload (
		.clk_in          (ref_clk_in),
		.reset_in        (reset_in),
		.rd_req_out      (nv_rd_req_out),
		.rd_addr_out     (nv_rd_addr_out),
		.rd_data_in      (nv_rd_data_in),
		.rd_valid_in     (nv_rd_valid_in),
		.load_strobe_out (ld_strobe),
		.load_sel_out    (ld_sel),
		.load_data_out   (ld_data),
		.done_out        (ld_done)
	);

	fcp_clkdiv u_clkdiv (
		.clk_in      (ref_clk_in),
		.reset_in    (reset_in),
		.osc_tick_in (osc_tick_in),
		.enable_in   (div_loaded),
		.prescale_in (prescale_select),
		.div_in      (divide_field),
		.tick_out    (fclk_tick_out)
	);

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------
	assign aw_take   = s_axi_awvalid_in && s_axi_awready_out;
	assign w_take    = s_axi_wvalid_in && s_axi_wready_out;
	assign ar_take   = s_axi_arvalid_in && s_axi_arready_out;
	assign do_write  = aw_got && w_got && !s_axi_bvalid_out;
	assign aw_idx    = aw_addr[5:2];
	assign ar_idx    = s_axi_araddr_in[5:2];
	assign aw_map    = aw_addr[7:6] == 2'h0 && aw_idx <= FCP_IDX_STAT;
	assign ar_map    = s_axi_araddr_in[7:6] == 2'h0 && ar_idx <= FCP_IDX_STAT;
	assign wr_lane   = do_write && aw_map && w_strb[0];
	assign broadcast_write_eff = broadcast_write && special_mode_in;
	assign bank_hit  = {broadcast_write_eff || bank_choose, broadcast_write_eff || !bank_choose};

	always_comb begin
		next_aw_got = aw_got ? !do_write : aw_take;
		next_w_got  = w_got ? !do_write : w_take;
		next_bvalid = do_write || (s_axi_bvalid_out && !s_axi_bready_in);
		next_rvalid = ar_take || (s_axi_rvalid_out && !s_axi_rready_in);
	end

	// Ready stays low until the nonvolatile loads are in place.
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			aw_got            <= 1'b0;
			w_got             <= 1'b0;
			aw_addr           <= 8'h00;
			w_data            <= 32'h0;
			w_strb            <= 4'h0;
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out  <= 1'b0;
			s_axi_bvalid_out  <= 1'b0;
			s_axi_bresp_out   <= FCP_RESP_OK;
		end else begin
			aw_got            <= next_aw_got;
			w_got             <= next_w_got;
			s_axi_bvalid_out  <= next_bvalid;
			s_axi_awready_out <= ld_done && !next_aw_got && !next_bvalid;
			s_axi_wready_out  <= ld_done && !next_w_got && !next_bvalid;
			if (aw_take)
				aw_addr <= s_axi_awaddr_in;
			if (w_take) begin
				w_data <= s_axi_wdata_in;
				w_strb <= s_axi_wstrb_in;
			end
			if (do_write)
				s_axi_bresp_out <= aw_map ? FCP_RESP_OK : FCP_RESP_ERR;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_comb begin
		rd_byte = 8'h00;
		unique case (ar_idx)
			FCP_IDX_DIV:  rd_byte = {div_loaded, prescale_select, divide_field};
			FCP_IDX_SEC:  rd_byte = lock_register;
			FCP_IDX_TST:  rd_byte = special_mode_in ? {3'h0, broadcast_write, 4'h0} : 8'h00;
			FCP_IDX_CFG:  rd_byte = {buffer_empty_irq_enable, complete_irq_enable,
				key_write_gate, 4'h0, bank_choose};
			FCP_IDX_PROT: rd_byte = protect_register[bank_choose];
			FCP_IDX_STAT: rd_byte = {buffer_empty_flag_in[bank_choose],
				complete_flag_in[bank_choose], guard_violation_flag[bank_choose],
				5'h00};
			default:      rd_byte = 8'h00;
		endcase
		if (!ar_map)
			rd_byte = 8'h00;
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rdata_out   <= 32'h0;
			s_axi_rresp_out   <= FCP_RESP_OK;
		end else begin
			s_axi_rvalid_out  <= next_rvalid;
			s_axi_arready_out <= ld_done && !next_rvalid;
			if (ar_take) begin
				s_axi_rdata_out <= {24'h0, rd_byte};
				s_axi_rresp_out <= ar_map ? FCP_RESP_OK : FCP_RESP_ERR;
			end
		end
	end

	// ----------------------------------------------------------------
	// Divider, test and configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			div_loaded      <= 1'b0;
			prescale_select <= 1'b0;
			divide_field    <= 6'h0;
		end else if (wr_lane && aw_idx == FCP_IDX_DIV && !div_loaded) begin
			div_loaded      <= 1'b1;
			prescale_select <= w_data[FCP_DIV_PRE];
			divide_field    <= w_data[5:0];
		end
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			broadcast_write <= 1'b0;
		end else if (wr_lane && aw_idx == FCP_IDX_TST && special_mode_in) begin
			broadcast_write <= w_data[FCP_TST_BROADCAST_WRITE];
		end
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			buffer_empty_irq_enable <= 1'b0;
			complete_irq_enable     <= 1'b0;
			key_write_gate          <= 1'b0;
			bank_choose             <= 1'b0;
		end else if (wr_lane && aw_idx == FCP_IDX_CFG) begin
			buffer_empty_irq_enable <= w_data[FCP_CFG_BEIE];
			complete_irq_enable     <= w_data[FCP_CFG_COMPLETE_IRQ_ENABLE];
			key_write_gate          <= w_data[FCP_CFG_KEY];
			bank_choose             <= w_data[FCP_CFG_BANK];
		end
	end

	// ----------------------------------------------------------------
	// Lock and protection registers
	// ----------------------------------------------------------------
	// Software writes never reach the lock register.
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			lock_register <= 8'h00;
		end else begin
			if (ld_strobe && ld_sel == FCP_LD_SEC)
				lock_register <= ld_data;
			if (backdoor_unlock_in)
				lock_register[1:0] <= FCP_UNSECURED;
		end
	end

	for (genvar b = 0; b < 2; b++) begin : g_bank
		always_ff @(posedge ref_clk_in or posedge reset_in) begin
			if (reset_in) begin
				protect_register[b] <= 8'h00;
			end else if (ld_strobe && ((b == 0 && ld_sel == FCP_LD_PROT0) ||
				(b == 1 && ld_sel == FCP_LD_PROT1))) begin
				protect_register[b] <= ld_data;
			end else if (wr_lane && aw_idx == FCP_IDX_PROT && bank_hit[b]) begin
				protect_register[b] <= fcp_prot_write(protect_register[b],
					w_data[7:0]);
			end
		end

		// No violation registers while a flag is set, so the clearing write always clears it.
		always_ff @(posedge ref_clk_in or posedge reset_in) begin
			if (reset_in) begin
				guard_violation_flag[b] <= 1'b0;
			end else if (viol && op_bank_in == b[0]) begin
				guard_violation_flag[b] <= 1'b1;
			end else if (wr_lane && aw_idx == FCP_IDX_STAT && bank_hit[b] &&
				w_data[FCP_ST_GUARD_VIOLATION_FLAG]) begin
				guard_violation_flag[b] <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Program and erase check, outputs
	// ----------------------------------------------------------------
	assign viol = op_req_in && !(|guard_violation_flag) &&
		fcp_is_protected(protect_register[op_bank_in], op_addr_in,
		op_mass_in);

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			op_grant_out           <= 1'b0;
			op_refuse_out          <= 1'b0;
			launch_block_out       <= 1'b0;
			irq_buffer_empty_out   <= 1'b0;
			irq_complete_out       <= 1'b0;
			key_write_gate_out     <= 1'b0;
			array_read_invalid_out <= 1'b0;
			bank_choose_out        <= 1'b0;
			broadcast_write_out    <= 1'b0;
			secured_out            <= 1'b1;
			backdoor_allow_out     <= 1'b0;
		end else begin
			op_grant_out  <= op_req_in && !(|guard_violation_flag) && !viol;
			op_refuse_out <= op_req_in && (viol || (|guard_violation_flag));
			launch_block_out     <= |guard_violation_flag;
			irq_buffer_empty_out <= buffer_empty_irq_enable &&
				(|buffer_empty_flag_in);
			irq_complete_out     <= complete_irq_enable &&
				(|complete_flag_in);
			key_write_gate_out     <= key_write_gate;
			array_read_invalid_out <= key_write_gate;
			bank_choose_out        <= bank_choose;
			broadcast_write_out    <= broadcast_write_eff;
			secured_out <= lock_register[1:0] != FCP_UNSECURED;
			backdoor_allow_out <= lock_register[FCP_SEC_BACKDOOR_ALLOW];
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_div_once;
		@(posedge ref_clk_in) disable iff (reset_in)
		div_loaded |=> $stable(divide_field) && $stable(prescale_select);
	endproperty
	a_div_once: assert property (p_div_once)
		else $error("divider changed after first write");

	property p_lock_ro;
		@(posedge ref_clk_in) disable iff (reset_in)
		wr_lane && aw_idx == FCP_IDX_SEC && !ld_strobe && !backdoor_unlock_in
		|=> $stable(lock_register);
	endproperty
	a_lock_ro: assert property (p_lock_ro)
		else $error("lock register changed by software write");

	property p_unlock;
		@(posedge ref_clk_in) disable iff (reset_in)
		backdoor_unlock_in |=> lock_register[1:0] == FCP_UNSECURED ##1 !secured_out;
	endproperty
	a_unlock: assert property (p_unlock)
		else $error("backdoor unlock did not unsecure");

	property p_tst_user;
		@(posedge ref_clk_in) disable iff (reset_in)
		ar_take && ar_idx == FCP_IDX_TST && !special_mode_in
		|=> s_axi_rdata_out == 32'h0;
	endproperty
	a_tst_user: assert property (p_tst_user)
		else $error("test register nonzero in user mode");

	property p_cfg_zero;
		@(posedge ref_clk_in) disable iff (reset_in)
		ar_take && ar_idx == FCP_IDX_CFG |=> s_axi_rdata_out[4:1] == 4'h0;
	endproperty
	a_cfg_zero: assert property (p_cfg_zero)
		else $error("configuration bits 4-1 not zero");

	property p_irq_be;
		@(posedge ref_clk_in) disable iff (reset_in)
		irq_buffer_empty_out |-> $past(buffer_empty_irq_enable) &&
			$past(|buffer_empty_flag_in);
	endproperty
	a_irq_be: assert property (p_irq_be)
		else $error("buffer empty request without enable and flag");

	property p_open_oneway;
		@(posedge ref_clk_in) disable iff (reset_in)
		!protect_register[0][FCP_PR_OPEN] && !ld_strobe
		|=> !protect_register[0][FCP_PR_OPEN];
	endproperty
	a_open_oneway: assert property (p_open_oneway)
		else $error("protect open bit set by software");

	property p_refuse;
		@(posedge ref_clk_in) disable iff (reset_in)
		viol |=> op_refuse_out && !op_grant_out ##1 launch_block_out;
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("protected operation not refused and flagged");

	property p_block;
		@(posedge ref_clk_in) disable iff (reset_in)
		op_req_in && (|guard_violation_flag) |=> !op_grant_out;
	endproperty
	a_block: assert property (p_block)
		else $error("launch granted while violation set");
endmodule

// ==== tb/fcp_nv_model.sv ====
`timescale 1ns/1ps
module fcp_nv_model
	import fcp_pkg::*;
#(
	parameter logic [7:0] SEC_BYTE   = 8'h00,
	parameter logic [7:0] PROT0_BYTE = 8'h00,
	parameter logic [7:0] PROT1_BYTE = 8'h00
)(
	// Clock
	input  wire logic        clk_in,
	// Byte read port
	input  wire logic        req_in,
	input  wire logic [15:0] addr_in,
	output logic [7:0]       data_out,
	output logic             valid_out
);
	int         seed  = 32'h504c6840;
	logic [7:0] noise = 8'h00;
	initial valid_out = 1'b0;
	// Answers after a random wait; idle data moves so nothing stale shows.
	always @(posedge clk_in) begin
		valid_out <= req_in && (($random(seed) & 1) != 0);
		noise <= noise + 8'h3b;
	end
	always_comb begin
		data_out = noise;
		if (valid_out)
			case (addr_in)
				FCP_NV_SEC:   data_out = SEC_BYTE;
				FCP_NV_PROT0: data_out = PROT0_BYTE;
				FCP_NV_PROT1: data_out = PROT1_BYTE;
				default:      data_out = ~noise;
			endcase
	end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
	import fcp_pkg::*;
;
	localparam logic [7:0] SEC_B = 8'h85;
	localparam logic [7:0] P0 = 8'hff;
	localparam logic [7:0] P1 = 8'hb2;
	logic ref_clk_in = 1'b0, reset_in = 1'b1;
	logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
	logic s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in;
	logic s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out;
	logic s_axi_rready_in, osc_tick_in, fclk_tick_out, special_mode_in;
	logic backdoor_unlock_in, nv_rd_req_out, nv_rd_valid_in, op_req_in;
	logic op_bank_in, op_mass_in, op_grant_out, op_refuse_out;
	logic launch_block_out, irq_buffer_empty_out, irq_complete_out;
	logic key_write_gate_out, array_read_invalid_out, bank_choose_out;
	logic broadcast_write_out, secured_out, backdoor_allow_out;
	logic [7:0] s_axi_awaddr_in, s_axi_araddr_in, nv_rd_data_in;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
	logic [3:0] s_axi_wstrb_in;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
	logic [1:0] buffer_empty_flag_in, complete_flag_in;
	logic [15:0] nv_rd_addr_out, op_addr_in;
	logic [9:0] exp_q[$];
	int n_fail = 0, samples_checked = 0, seed = 32'h504c6840;

	fcp_top u_fcp_top (.*);
	fcp_nv_model #(.SEC_BYTE(SEC_B), .PROT0_BYTE(P0), .PROT1_BYTE(P1))
	u_fcp_nv_model (.clk_in(ref_clk_in), .req_in(nv_rd_req_out),
		.addr_in(nv_rd_addr_out), .data_out(nv_rd_data_in),
		.valid_out(nv_rd_valid_in));

	always #25 ref_clk_in = ~ref_clk_in;
	always @(posedge ref_clk_in)
		osc_tick_in <= ($random(seed) & 1) != 0;

	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= {24'h0, d};
		s_axi_bready_in <= 1'b1;
		fork
			begin
				do @(posedge ref_clk_in); while (s_axi_awready_out !== 1'b1);
				s_axi_awvalid_in <= 1'b0;
			end
			begin
				do @(posedge ref_clk_in); while (s_axi_wready_out !== 1'b1);
				s_axi_wvalid_in <= 1'b0;
			end
		join
		do @(posedge ref_clk_in); while (s_axi_bvalid_out !== 1'b1);
		s_axi_bready_in <= 1'b0;
	endtask

	// Notes the expected response and byte; the monitor compares them.
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back({(a > 8'h14) ? FCP_RESP_ERR : FCP_RESP_OK, e});
		@(posedge ref_clk_in);
		s_axi_arvalid_in <= 1'b1;
		s_axi_araddr_in <= a;
		s_axi_rready_in <= 1'b1;
		do @(posedge ref_clk_in); while (s_axi_arready_out !== 1'b1);
		s_axi_arvalid_in <= 1'b0;
		do @(posedge ref_clk_in); while (s_axi_rvalid_out !== 1'b1);
		s_axi_rready_in <= 1'b0;
	endtask

	// Expected answer is {grant, refuse}, one pulse after the request edge.
	task automatic op(input logic b, input logic [15:0] a, input logic m,
		input logic [1:0] e);
		@(posedge ref_clk_in);
		op_req_in <= 1'b1;
		op_bank_in <= b;
		op_addr_in <= a;
		op_mass_in <= m;
		@(posedge ref_clk_in);
		op_req_in <= 1'b0;
		#1 chk({op_grant_out, op_refuse_out}, e);
		repeat (2) @(posedge ref_clk_in);
	endtask

	always @(posedge ref_clk_in)
		if (s_axi_rvalid_out === 1'b1 && s_axi_rready_in)
			chk({s_axi_rresp_out, s_axi_rdata_out[7:0]}, exp_q.pop_front());

	initial begin
		repeat (5000) @(posedge ref_clk_in);
		n_fail++;
		conclude();
	end

	initial begin
		{s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= '0;
		{s_axi_arvalid_in, s_axi_rready_in, special_mode_in} <= '0;
		{backdoor_unlock_in, op_req_in, op_bank_in, op_mass_in} <= '0;
		{s_axi_awaddr_in, s_axi_araddr_in, op_addr_in} <= '0;
		s_axi_wdata_in <= '0;
		s_axi_wstrb_in <= 4'hf;
		buffer_empty_flag_in <= 2'b10;
		complete_flag_in <= 2'b01;
		repeat (10) @(posedge ref_clk_in);
		reset_in <= 1'b0;
		rd(8'h04, SEC_B);
		rd(8'h10, P0);
		wr(8'h04, 8'h00);
		rd(8'h04, SEC_B);
		wr(8'h00, 8'hc5);
		wr(8'h00, 8'h7f);
		rd(8'h00, 8'hc5);
		wr(8'h0c, 8'hff);
		rd(8'h0c, 8'he1);
		chk({irq_buffer_empty_out, irq_complete_out, key_write_gate_out,
			array_read_invalid_out, bank_choose_out}, 10'h1f);
		rd(8'h10, P1);
		op(1'b1, 16'h8000, 1'b0, 2'b01);
		rd(8'h14, 8'ha0);
		wr(8'h14, 8'h20);
		rd(8'h14, 8'h80);
		op(1'b1, 16'h0000, 1'b1, 2'b01);
		rd(8'h14, 8'ha0);
		wr(8'h14, 8'h20);
		wr(8'h0c, 8'h00);
		op(1'b0, 16'h0000, 1'b1, 2'b10);
		rd(8'h14, 8'h40);
		wr(8'h08, 8'h10);
		rd(8'h08, 8'h00);
		special_mode_in <= 1'b1;
		wr(8'h08, 8'h10);
		rd(8'h08, 8'h10);
		wr(8'h10, 8'h00);
		rd(8'h10, 8'h40);
		wr(8'h0c, 8'h01);
		rd(8'h10, 8'h02);
		rd(8'h20, 8'h00);
		@(posedge ref_clk_in);
		backdoor_unlock_in <= 1'b1;
		@(posedge ref_clk_in);
		backdoor_unlock_in <= 1'b0;
		rd(8'h04, 8'h86);
		chk({secured_out, backdoor_allow_out}, 10'h1);
		conclude();
	end
endmodule
